// ### design/avi_cfg.svh
// constants for the accumulator velocity and indexed variable command slice
// Summary of operation
// - rotate-right opcode 51: velocity mode, load target velocity
// - accumulator speed counts microsteps per second
// - set-indexed writes direct value at X index
// - X outside 0..255 ignores indexed commands
// - set-indexed opcode 55 (37h), value in bytes
// - get-indexed 38h copies variable into accumulator
// - accumulator-to-indexed 39h copies accumulator into variable
`ifndef AVI_CFG_SVH
`define AVI_CFG_SVH
`define AVI_OP_ROTATE_RIGHT   8'h33
`define AVI_OP_SET_INDEXED    8'h37
`define AVI_OP_GET_INDEXED    8'h38
`define AVI_OP_ACC_TO_INDEXED 8'h39
`define AVI_STATUS_OK         8'h64
`define AVI_STATUS_BAD_CSUM   8'h01
`define AVI_STATUS_BAD_CMD    8'h02
`define AVI_AXIS_TARGET_VEL   8'h02
`define AVI_FRAME_LEN         4'h9
`define AVI_MODE_VELOCITY     1'b1
`define AVI_MODE_POSITION     1'b0
`endif

// ### design/avi_core.sv
// command interpreter slice: rotate right from accumulator and indexed variables
`timescale 1ns/1ps
`include "avi_cfg.svh"
module avi_core (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // command byte stream
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  // interpreter registers loaded by other commands
  input  wire logic        acc_load,
  input  wire logic [31:0] acc_load_value,
  input  wire logic        x_load,
  input  wire logic [31:0] x_load_value,
  // reply
  output      logic        reply_valid,
  output      logic [7:0]  reply_status,
  output      logic [7:0]  reply_command,
  output      logic [31:0] reply_value,
  // axis outputs
  output      logic        axis_velocity_mode,
  output      logic [31:0] axis_target_velocity,
  output      logic        axis_update,
  output      logic [7:0]  axis_param_number,
  // state visible to the program side
  output      logic [31:0] accumulator,
  output      logic [31:0] x_register,
  output      logic        busy
);
  avi_pkg::avi_state_t state;
  avi_pkg::avi_state_t next_state;

  logic [3:0]  byte_count;
  logic [7:0]  frame [0:7];
  logic [7:0]  csum;
  logic [31:0] mem_rd_data;

  // frame fields, value most significant byte first
  wire logic [7:0]  f_instr = frame[1];
  wire logic [31:0] f_value = {frame[4], frame[5], frame[6], frame[7]};
  wire logic        frame_end = rx_valid && (byte_count == 4'h8);
  wire logic        csum_ok   = (csum == rx_byte);

  // an index outside 0..255 means the upper 24 bits are not all zero
  function automatic logic x_in_range(input logic [31:0] x);
    x_in_range = (x[31:8] == 24'h000000);
  endfunction

  wire logic x_ok        = x_in_range(x_register);
  wire logic [7:0] x_idx = x_register[7:0];
  wire logic is_rot      = (f_instr == `AVI_OP_ROTATE_RIGHT);
  wire logic is_set      = (f_instr == `AVI_OP_SET_INDEXED);
  wire logic is_get      = (f_instr == `AVI_OP_GET_INDEXED);
  wire logic is_a2i      = (f_instr == `AVI_OP_ACC_TO_INDEXED);
  wire logic is_known    = is_rot | is_set | is_get | is_a2i;
  wire logic in_exec     = (state == avi_pkg::AVI_EXEC);
  wire logic mem_we      = in_exec && x_ok && (is_set || is_a2i);
  wire logic [31:0] mem_wd = is_set ? f_value : accumulator;

  always_comb begin
    next_state = state;
    unique case (state)
      avi_pkg::AVI_IDLE: begin
        if (frame_end) begin
          next_state = csum_ok ? avi_pkg::AVI_EXEC : avi_pkg::AVI_REPLY;
        end
      end
      avi_pkg::AVI_EXEC: begin
        next_state = (is_get && x_ok) ? avi_pkg::AVI_RDWT : avi_pkg::AVI_REPLY;
      end
      avi_pkg::AVI_RDWT:  next_state = avi_pkg::AVI_LOAD;
      avi_pkg::AVI_LOAD:  next_state = avi_pkg::AVI_REPLY;
      avi_pkg::AVI_REPLY: next_state = avi_pkg::AVI_IDLE;
      default:            next_state = avi_pkg::AVI_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= avi_pkg::AVI_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // byte collection; bytes arriving while a frame executes are dropped
  wire logic       take_byte       = rx_valid && (state == avi_pkg::AVI_IDLE);
  wire logic [3:0] next_byte_count = frame_end ? 4'h0 : byte_count + 4'h1;
  wire logic [7:0] next_csum       = frame_end ? 8'h00 : csum + rx_byte;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      byte_count <= 4'h0;
    end else if (take_byte) begin
      byte_count <= next_byte_count;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      csum <= 8'h00;
    end else if (take_byte) begin
      csum <= next_csum;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_frame
      wire logic grab = take_byte && (byte_count == 4'(gi));
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          frame[gi] <= 8'h00;
        end else if (grab) begin
          frame[gi] <= rx_byte;
        end
      end
    end
  endgenerate

  avi_var_mem u_mem (
    .sys_clk (sys_clk),
    .wr_en   (mem_we),
    .wr_addr (x_idx),
    .wr_data (mem_wd),
    .rd_addr (x_idx),
    .rd_data (mem_rd_data)
  );

  // accumulator and X register; a variable read wins over a program-side load
  wire logic        acc_from_mem     = (state == avi_pkg::AVI_LOAD);
  wire logic        acc_we           = acc_from_mem || acc_load;
  wire logic [31:0] next_accumulator = acc_from_mem ? mem_rd_data : acc_load_value;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      accumulator <= 32'h00000000;
    end else if (acc_we) begin
      accumulator <= next_accumulator;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      x_register <= 32'h00000000;
    end else if (x_load) begin
      x_register <= x_load_value;
    end
  end

  // axis: speed is the accumulator in microsteps per second, positive = right
  wire logic start_rotate = in_exec && is_rot;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      axis_update <= 1'b0;
    end else begin
      axis_update <= start_rotate;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      axis_velocity_mode <= `AVI_MODE_POSITION;
    end else if (start_rotate) begin
      axis_velocity_mode <= `AVI_MODE_VELOCITY;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      axis_target_velocity <= 32'h00000000;
    end else if (start_rotate) begin
      axis_target_velocity <= accumulator;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      axis_param_number <= `AVI_AXIS_TARGET_VEL;
    end else begin
      axis_param_number <= `AVI_AXIS_TARGET_VEL;
    end
  end

  // reply: one-cycle pulse, ok for executed or ignored indexed commands
  wire logic        enter_reply       = (next_state == avi_pkg::AVI_REPLY);
  wire logic        reply_from_idle   = (state == avi_pkg::AVI_IDLE);
  wire logic        next_busy         = (next_state != avi_pkg::AVI_IDLE);
  wire logic [31:0] next_reply_value  = acc_from_mem ? mem_rd_data : accumulator;
  wire logic [7:0]  next_reply_status = reply_from_idle ? `AVI_STATUS_BAD_CSUM :
                                        !is_known       ? `AVI_STATUS_BAD_CMD  :
                                                          `AVI_STATUS_OK;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= next_busy;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reply_valid <= 1'b0;
    end else begin
      reply_valid <= enter_reply;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reply_status <= 8'h00;
    end else if (enter_reply) begin
      reply_status <= next_reply_status;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reply_command <= 8'h00;
    end else if (enter_reply) begin
      reply_command <= f_instr;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reply_value <= 32'h00000000;
    end else if (enter_reply) begin
      reply_value <= next_reply_value;
    end
  end
endmodule

// ### design/avi_pkg.sv
// types for the accumulator velocity and indexed variable command slice
package avi_pkg;
  typedef enum logic [2:0] {
    AVI_IDLE  = 3'b000,
    AVI_EXEC  = 3'b001,
    AVI_RDWT  = 3'b010,
    AVI_LOAD  = 3'b011,
    AVI_REPLY = 3'b100
  } avi_state_t;
endpackage

// ### design/avi_var_mem.sv
// 256 x 32 user variable memory with registered read data
`timescale 1ns/1ps
module avi_var_mem (
  // clock
  input  wire logic        sys_clk,
  // write port
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_addr,
  input  wire logic [31:0] wr_data,
  // read port
  input  wire logic [7:0]  rd_addr,
  output      logic [31:0] rd_data
);
  logic [31:0] mem [0:255];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ### sim/avi_core_assertions.sv
// port assertions for the command interpreter
`timescale 1ns/1ps
module avi_core_assertions (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        arst_n,
  // observed ports
  input wire logic        acc_load,
  input wire logic        reply_valid,
  input wire logic [7:0]  reply_status,
  input wire logic        axis_velocity_mode,
  input wire logic [31:0] axis_target_velocity,
  input wire logic        axis_update,
  input wire logic [7:0]  axis_param_number,
  input wire logic [31:0] accumulator,
  input wire logic        busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_update_ok_reply: assert property (axis_update |-> reply_valid && reply_status == 8'h64)
    else $error("axis update without ok reply");
  a_update_vel_mode: assert property (axis_update |-> axis_velocity_mode)
    else $error("velocity mode not set");
  a_target_from_acc: assert property (axis_update |-> axis_target_velocity == $past(accumulator))
    else $error("target velocity differs from accumulator");
  a_param_is_two: assert property (axis_param_number == 8'h02)
    else $error("wrong axis parameter number");
  a_reply_one_cycle: assert property (reply_valid |=> !reply_valid)
    else $error("reply longer than one cycle");
  a_busy_then_reply: assert property ($rose(busy) |-> ##[0:3] reply_valid)
    else $error("no reply after frame");
  a_idle_after_reply: assert property (reply_valid |=> !busy)
    else $error("busy after reply");
  a_acc_held_idle: assert property (!busy && !acc_load |=> $stable(accumulator))
    else $error("accumulator changed while idle");
  cover property (axis_update);
  cover property (reply_valid && reply_status == 8'h01);
  cover property ($changed(accumulator) && busy);
endmodule
bind avi_core avi_core_assertions i_avi_core_assertions (.*);

// ### sim/avi_core_tb.sv
// self-checking bench for the command interpreter
`timescale 1ns/1ps
module avi_core_tb;
  logic        sys_clk, arst_n, rx_valid, acc_load, x_load, reply_valid, busy;
  logic        axis_velocity_mode, axis_update;
  logic [7:0]  rx_byte, reply_status, reply_command, axis_param_number;
  logic [31:0] acc_load_value, x_load_value, reply_value, axis_target_velocity;
  logic [31:0] accumulator, x_register, a1, v;
  logic [31:0] mem [int];
  int          miscompares, num_checks, cycles, acc;
  int          xs [5] = '{0, 256, -1, 255, 0};
  avi_core i_avi_core (.*);
  avi_host_model i_avi_host_model (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op, input logic [31:0] val, input logic bad);
    i_avi_host_model.send(op, val, bad, $urandom_range(0, 1));
    for (int i = 0; i < 8 && reply_valid !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    check(reply_valid, 1'b1);
    check(reply_status, bad ? 8'h01 : (op inside {8'h33, [8'h37:8'h39]} ? 8'h64 : 8'h02));
    check(reply_command, op);
    check(axis_update, !bad && op == 8'h33);
  endtask
  task automatic load(input logic [31:0] a, input logic [31:0] x);
    @(posedge sys_clk);
    #1 {acc_load, x_load, acc_load_value, x_load_value} = {2'b11, a, x};
    @(posedge sys_clk);
    #1 {acc_load, x_load} = 2'b00;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    {arst_n, acc_load, x_load, acc_load_value, x_load_value} = '0;
    void'($urandom(71));
    repeat (12) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    check(axis_param_number, 8'h02);
    check(axis_velocity_mode, 1'b0);
    acc = $urandom;
    load(acc, 0);
    cmd(8'h33, 32'h0, 1'b0);
    check(axis_target_velocity, acc);
    check(reply_value, acc);
    check(axis_velocity_mode, 1'b1);
    $display("rotate test done");
    foreach (xs[i]) begin
      if (i == 4) xs[i] = $urandom_range(1, 254);
      {a1, v, acc} = {$urandom, $urandom, $urandom};
      load(a1, xs[i]);
      check(x_register, xs[i]);
      cmd(8'h39, 32'h0, 1'b0);
      if (xs[i] inside {[0:255]}) mem[xs[i]] = a1;
      load(acc, xs[i]);
      cmd(8'h38, 32'h0, 1'b0);
      if (xs[i] inside {[0:255]}) acc = mem[xs[i]];
      check(accumulator, acc);
      check(reply_value, acc);
      cmd(8'h37, v, 1'b0);
      if (xs[i] inside {[0:255]}) mem[xs[i]] = v;
      cmd(8'h38, 32'h0, 1'b0);
      if (xs[i] inside {[0:255]}) acc = mem[xs[i]];
      check(accumulator, acc);
    end
    $display("indexed test done");
    load(acc, 0);
    cmd(8'h38, 32'h0, 1'b1);
    check(accumulator, acc);
    cmd(8'h3a, $urandom, 1'b0);
    check(accumulator, acc);
    cmd(8'h38, 32'h0, 1'b0);
    check(accumulator, mem[0]);
    check(reply_value, mem[0]);
    $display("checksum test done");
    summarize();
  end
endmodule

// ### sim/avi_host_model.sv
// host model sending framed command bytes
`timescale 1ns/1ps
module avi_host_model (
  // clock
  input wire logic       sys_clk,
  // byte stream
  output     logic       rx_valid,
  output     logic [7:0] rx_byte
);
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end
  task automatic send(input logic [7:0] op, input logic [31:0] v, input logic bad,
                      input int slow);
    logic [7:0] f [9];
    f = '{8'h01, op, 8'h00, 8'h00, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    for (int i = 0; i < 8; i++) f[8] += f[i];
    f[8] ^= {7'h0, bad};
    for (int i = 0; i < 9; i++) begin
      repeat (slow) begin
        @(posedge sys_clk);
        #1 rx_valid = 1'b0;
        rx_byte = ~rx_byte;
      end
      @(posedge sys_clk);
      #1 rx_valid = 1'b1;
      rx_byte = f[i];
    end
    @(posedge sys_clk);
    #1 rx_valid = 1'b0;
    rx_byte = ~rx_byte;
  endtask
endmodule
